// file: core/apc_params.svh
/*
 Constants for the absolute page call execution block.
 Assumes inclusion by bare name from the package and the design module.
*/
// How it works
// - On a page call the return address is the three-byte PC plus two, pushed low byte first then the next byte.
// - The stack pointer is advanced by one before each of the two stack writes, ending two higher.
// - The target is PC[23:11] after the increment, then opcode[7:5], then the whole second byte.
// - The call is recognised when opcode[4:0] is 10001; opcode[7:5] give target[10:8], byte two target[7:0].
// - Only the low eleven PC bits are replaced, so the target stays in the 2-Kbyte page of the next instruction.
// - The call leaves carry, auxiliary carry, overflow, negative and zero flags unchanged.
// - A flag-dependent conditional jump decides from the flag value held before it starts executing.
`ifndef APC_PARAMS_SVH
`define APC_PARAMS_SVH
`define APC_CALL_LOW_CODE 5'h11
`define APC_RET_INC       24'h000002
`define APC_SP_RESET      8'h07
`define APC_PC_RESET      24'h000000
`define APC_PAGE_BITS     11
`endif

// file: core/apc_pkg.sv
/*
 Types for the absolute page call execution block.
 Assumes the params header is on the include path.
*/
`include "apc_params.svh"
package apc_pkg;
	typedef enum logic [1:0] {
		APC_IDLE  = 2'b00,
		APC_PUSH0 = 2'b01,
		APC_PUSH1 = 2'b10
	} apc_state_e;
	typedef struct packed {
		logic       carry_flag;
		logic       auxiliary_carry_flag;
		logic       overflow_flag;
		logic       negative_flag;
		logic       zero_flag;
	} apc_flags_s;
	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} apc_wr_s;
endpackage

// file: core/apc_absolute_page_call.sv
/*
 Executes the two-byte absolute page call: pushes the low two bytes of the return address,
 advances the stack pointer and loads the in-page target. Also resolves
 flag-dependent branch decisions from the flags held before execution.
 Assumes instruction bytes arrive with a one-cycle start pulse from the
 fetch logic and that the flag registers are owned elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apc_params.svh"
module apc_absolute_page_call
	import apc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       start,
	input  wire logic [7:0] opcode,
	input  wire logic [7:0] operand,
	input  wire logic [23:0] pc_in,
	input  wire logic [7:0] sp_in,
	input  wire apc_flags_s flags_in,
	input  wire logic       jump_cond_sel,
	input  wire logic       jump_on_set,
	output logic            busy,
	output logic            done,
	output logic            not_call,
	output logic [23:0]     pc_out,
	output logic [7:0]      sp_out,
	output apc_wr_s         mem_wr,
	output apc_flags_s      flags_out,
	output logic            branch_taken
);
	apc_state_e state;
	apc_state_e next_state;
	logic [23:0] ret;
	logic [23:0] next_ret;
	logic [23:0] next_pc_out;
	logic [7:0]  next_sp_out;
	logic [2:0]  hi_bits;
	logic [2:0]  next_hi_bits;
	logic [7:0]  lo_bits;
	logic [7:0]  next_lo_bits;
	apc_wr_s     next_mem_wr;
	apc_flags_s  next_flags_out;
	logic        next_busy;
	logic        next_done;
	logic        next_not_call;
	logic        next_branch_taken;
	logic        is_call;

	assign is_call = (opcode[4:0] == `APC_CALL_LOW_CODE);

	always_comb begin
		next_state = state;
		next_ret = ret;
		next_pc_out = pc_out;
		next_sp_out = sp_out;
		next_hi_bits = hi_bits;
		next_lo_bits = lo_bits;
		next_mem_wr = '0;
		next_flags_out = flags_out;
		next_busy = busy;
		next_done = 1'b0;
		next_not_call = 1'b0;
		next_branch_taken = branch_taken;
		unique case (state)
			APC_IDLE: begin
				if (start) begin
					// Flags sampled at start, before any effect of the instruction
					next_branch_taken = jump_on_set ==
						(jump_cond_sel ? flags_in.carry_flag : flags_in.zero_flag);
					next_flags_out = flags_in;
					if (is_call) begin
						next_ret = pc_in + `APC_RET_INC;
						next_hi_bits = opcode[7:5];
						next_lo_bits = operand;
						next_sp_out = sp_in;
						next_busy = 1'b1;
						next_state = APC_PUSH0;
					end else begin
						next_not_call = 1'b1;
					end
				end
			end
			APC_PUSH0: begin
				next_sp_out = sp_out + 8'h01;
				next_mem_wr = '{we: 1'b1, addr: sp_out + 8'h01, data: ret[7:0]};
				next_state = APC_PUSH1;
			end
			APC_PUSH1: begin
				next_sp_out = sp_out + 8'h01;
				next_mem_wr = '{we: 1'b1, addr: sp_out + 8'h01, data: ret[15:8]};
				// Only the low page bits change; the upper bits keep PC plus two
				next_pc_out = {ret[23:`APC_PAGE_BITS], hi_bits, lo_bits};
				next_busy = 1'b0;
				next_done = 1'b1;
				next_state = APC_IDLE;
			end
			default: next_state = APC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= APC_IDLE;
			ret <= '0;
			pc_out <= `APC_PC_RESET;
			sp_out <= `APC_SP_RESET;
			hi_bits <= '0;
			lo_bits <= '0;
			mem_wr <= '0;
			flags_out <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			not_call <= 1'b0;
			branch_taken <= 1'b0;
		end else begin
			state <= next_state;
			ret <= next_ret;
			pc_out <= next_pc_out;
			sp_out <= next_sp_out;
			hi_bits <= next_hi_bits;
			lo_bits <= next_lo_bits;
			mem_wr <= next_mem_wr;
			flags_out <= next_flags_out;
			busy <= next_busy;
			done <= next_done;
			not_call <= next_not_call;
			branch_taken <= next_branch_taken;
		end
	end

	// Independent copies of the return address and target, kept as plain
	// signals so that each property samples them with a simple $past
	logic [23:0] chk_ret;
	logic [7:0]  chk_ret_lo;
	logic [7:0]  chk_ret_hi;
	logic [4:0]  chk_ret_page;
	logic [7:0]  chk_ret_top;
	logic [10:0] chk_target;
	logic        chk_take_call;
	logic        chk_take_other;

	assign chk_ret        = pc_in + 24'h000002;
	assign chk_ret_lo     = chk_ret[7:0];
	assign chk_ret_hi     = chk_ret[15:8];
	assign chk_ret_page   = chk_ret[15:11];
	assign chk_ret_top    = chk_ret[23:16];
	assign chk_target     = {opcode[7:5], operand};
	// Decoded again here so that a broken is_call cannot hide behind itself
	assign chk_take_call  = start && !busy && (opcode[4:0] == 5'h11);
	assign chk_take_other = start && !busy && (opcode[4:0] != 5'h11);

	a_first_push_low: assert property (
		@(posedge core_clk) disable iff (srst)
		chk_take_call |-> ##2 (mem_wr.we && mem_wr.data == $past(chk_ret_lo, 2)
			&& mem_wr.addr == $past(sp_in, 2) + 8'h01))
		else $error("first push not low return byte");
	a_second_push_hi: assert property (
		@(posedge core_clk) disable iff (srst)
		chk_take_call |-> ##3 (mem_wr.we && mem_wr.data == $past(chk_ret_hi, 3)
			&& mem_wr.addr == $past(sp_in, 3) + 8'h02))
		else $error("second push not next return byte");
	a_sp_plus_two: assert property (
		@(posedge core_clk) disable iff (srst)
		chk_take_call |-> ##3 (sp_out == $past(sp_in, 3) + 8'h02))
		else $error("stack pointer not advanced by two");
	a_sp_step_each: assert property (
		@(posedge core_clk) disable iff (srst)
		mem_wr.we |-> mem_wr.addr == sp_out)
		else $error("write not at advanced stack pointer");
	// The pointer may move only while a call is pushing
	a_sp_hold_idle: assert property (
		@(posedge core_clk) disable iff (srst)
		!busy && !done && !$past(srst) |-> $stable(sp_out))
		else $error("stack pointer moved outside a call");
	a_target_form: assert property (
		@(posedge core_clk) disable iff (srst)
		chk_take_call |-> ##3 (done && pc_out[10:0] == $past(chk_target, 3)))
		else $error("target low bits wrong");
	a_page_kept: assert property (
		@(posedge core_clk) disable iff (srst)
		chk_take_call |-> ##3 (pc_out[15:11] == $past(chk_ret_page, 3)
			&& pc_out[23:16] == $past(chk_ret_top, 3)))
		else $error("page or high pc bits changed");
	// Only a finished call may load the program counter
	a_pc_hold: assert property (
		@(posedge core_clk) disable iff (srst)
		!done && !$past(srst) |-> $stable(pc_out))
		else $error("pc changed without a call");
	a_decode_other: assert property (
		@(posedge core_clk) disable iff (srst)
		chk_take_other |=> not_call && !busy && !mem_wr.we)
		else $error("non-call opcode started a call");
	// A start offered mid-call is dropped and the call runs on to its end
	a_refused_start: assert property (
		@(posedge core_clk) disable iff (srst)
		start && busy |=> !not_call && (busy || done))
		else $error("start taken while busy");
	a_done_ends_busy: assert property (
		@(posedge core_clk) disable iff (srst)
		done |-> !busy && $past(busy))
		else $error("done without a finished push pair");
	a_flags_kept: assert property (
		@(posedge core_clk) disable iff (srst)
		start && !busy |=> flags_out == $past(flags_in))
		else $error("flags changed by call");
	a_branch_prior: assert property (
		@(posedge core_clk) disable iff (srst)
		start && !busy |=> branch_taken == ($past(jump_on_set) ==
			($past(jump_cond_sel) ? $past(flags_in.carry_flag) : $past(flags_in.zero_flag))))
		else $error("branch not from prior flag");

	// Main scenarios: a call, a non-call, a taken branch, a wrap, a refused start
	c_call_done: cover property (@(posedge core_clk) disable iff (srst)
		chk_take_call ##3 done);
	c_not_call: cover property (@(posedge core_clk) disable iff (srst)
		chk_take_other ##1 not_call);
	c_branch: cover property (@(posedge core_clk) disable iff (srst)
		start ##1 branch_taken);
	c_sp_wrap: cover property (@(posedge core_clk) disable iff (srst)
		mem_wr.we && mem_wr.addr == 8'h00);
	c_refused: cover property (@(posedge core_clk) disable iff (srst)
		start && busy ##1 done);
endmodule // apc_absolute_page_call
`default_nettype wire

// file: bench/apc_absolute_page_call_tb.sv
/*
 Self-checking bench for the absolute page call block.
 Assumes the package and params header compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apc_params.svh"
module apc_absolute_page_call_tb
	import apc_pkg::*;
;
	logic        core_clk, srst, start, jump_cond_sel, jump_on_set;
	logic        busy, done, not_call, branch_taken;
	logic [7:0]  opcode, operand, sp_in, sp_out;
	logic [23:0] pc_in, pc_out;
	apc_flags_s  flags_in, flags_out;
	apc_wr_s     mem_wr;
	int          n_mismatch, checks_done;
	apc_absolute_page_call apc_absolute_page_call_i (.core_clk(core_clk), .srst(srst),
		.start(start), .opcode(opcode), .operand(operand), .pc_in(pc_in), .sp_in(sp_in),
		.flags_in(flags_in), .jump_cond_sel(jump_cond_sel), .jump_on_set(jump_on_set),
		.busy(busy), .done(done), .not_call(not_call), .pc_out(pc_out), .sp_out(sp_out),
		.mem_wr(mem_wr), .flags_out(flags_out), .branch_taken(branch_taken));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One start pulse; returns at the falling edge after the taking edge
	task automatic issue(logic [7:0] op, logic [7:0] opr, logic [23:0] pc, logic [7:0] sp,
		apc_flags_s fl);
		@(negedge core_clk);
		{opcode, operand, pc_in, sp_in, flags_in, start} = {op, opr, pc, sp, fl, 1'b1};
		@(negedge core_clk);
		start = 1'b0;
	endtask
	task automatic do_call(logic [7:0] op, logic [7:0] opr, logic [23:0] pc, logic [7:0] sp,
		apc_flags_s fl);
		logic [23:0] ret;
		int          nw;
		int          k;
		ret = pc + 24'h000002;
		nw = 0;
		issue(op, opr, pc, sp, fl);
		chk("flags", fl, flags_out);
		chk("busy", 1'b1, busy);
		chk("branch", jump_on_set == (jump_cond_sel ? fl.carry_flag : fl.zero_flag), branch_taken);
		for (k = 0; k < 8 && !done; k++) begin
			@(negedge core_clk);
			if (mem_wr.we === 1'b1) begin
				chk("addr", 8'(sp + nw + 1), mem_wr.addr);
				chk("data", nw ? ret[15:8] : ret[7:0], mem_wr.data);
				nw++;
			end
		end
		chk("done", 1'b1, done);
		if (done !== 1'b1)
			end_sim();
		chk("pushes", 24'h000002, 24'(nw));
		chk("pc", {ret[23:11], op[7:5], opr}, pc_out);
		chk("sp", 8'(sp + 8'h02), sp_out);
		chk("flags kept", fl, flags_out);
	endtask
	// Non-call opcode with every condition select and polarity
	task automatic do_branch;
		int i;
		for (i = 0; i < 4; i++) begin
			{jump_cond_sel, jump_on_set} = 2'(i);
			issue(8'h12, 8'h00, 24'h000100, 8'h30, 5'h10);
			chk("not_call", 1'b1, not_call);
			chk("branch", jump_on_set == (jump_cond_sel ? 1'b1 : 1'b0), branch_taken);
			chk("no push", 1'b0, mem_wr.we | busy);
		end
	endtask
	// A start offered while a call is pushing must be dropped
	task automatic do_refused;
		@(negedge core_clk);
		{opcode, operand, start} = {8'h31, 8'h20, 1'b1};
		{pc_in, sp_in, flags_in} = {24'h000400, 8'h10, 5'h00};
		@(negedge core_clk);
		{opcode, operand} = {8'h12, 8'h99};
		@(negedge core_clk);
		start = 1'b0;
		chk("refused busy", 1'b1, busy);
		chk("refused not_call", 1'b0, not_call);
		chk("refused push", 8'h02, mem_wr.data);
		@(negedge core_clk);
		chk("refused done", 1'b1, done);
		chk("refused pc", 24'h000120, pc_out);
		chk("refused sp", 8'h12, sp_out);
	endtask
	initial begin
		{start, opcode, operand, pc_in, sp_in, flags_in, jump_cond_sel, jump_on_set} = '0;
		n_mismatch = 0;
		checks_done = 0;
		srst = 1'b1;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		srst = 1'b0;
		chk("sp reset", `APC_SP_RESET, sp_out);
		chk("pc reset", `APC_PC_RESET, pc_out);
		do_call(8'h71, 8'h45, 24'h000123, 8'h07, 5'h15);
		// Return address crosses a page and the stack pointer wraps
		do_call(8'hf1, 8'hff, 24'h1207fe, 8'hfe, 5'h0a);
		for (int i = 0; i < 8; i++)
			do_call({3'(i), 5'h11}, 8'(i * 37), 24'h5a3f00 + 24'(i), 8'(i), 5'(i));
		do_branch();
		do_refused();
		end_sim();
	end
endmodule // apc_absolute_page_call_tb
`default_nettype wire
